// ---- tmr16_regs.vh ----
// register map and field positions of the 16-bit timer
// assumes the plain register port of tmr16_top: 8-bit address, 16-bit data
`ifndef TMR16_REGS_VH
`define TMR16_REGS_VH
// register addresses
`define TMR16_ADDR_COUNT    8'h00
`define TMR16_ADDR_CYCLE    8'h01
`define TMR16_ADDR_DUTY     8'h02
`define TMR16_ADDR_MODE     8'h03
`define TMR16_ADDR_CAPCMP   8'h04
`define TMR16_ADDR_OUTCTL   8'h05
`define TMR16_ADDR_PRESC    8'h06
`define TMR16_ADDR_STATUS   8'h07
// mode_control_reg fields
`define TMR16_MODE_OVF      0
`define TMR16_MODE_RUN_LO   2
`define TMR16_MODE_RUN_HI   3
// run modes
`define TMR16_RUN_STOP      2'b00
`define TMR16_RUN_EDGE      2'b01
`define TMR16_RUN_FREE      2'b10
`define TMR16_RUN_MATCH     2'b11
// capcmp_control_reg fields
`define TMR16_CC_CYC_CAP    0
`define TMR16_CC_SRC        1
`define TMR16_CC_DUTY_CAP   2
// output_control_reg fields
`define TMR16_OC_ENABLE     0
`define TMR16_OC_CYC_TGL    1
`define TMR16_OC_LVL_RST    2
`define TMR16_OC_LVL_SET    3
`define TMR16_OC_DUTY_TGL   4
`define TMR16_OC_OS_EN      5
`define TMR16_OC_OS_TRIG    6
`define TMR16_OC_MASK       16'h003B
`define TMR16_OC_RD_MASK    16'h0033
// prescaler_reg fields
`define TMR16_PR_CLK_LO     0
`define TMR16_PR_CLK_HI     1
`define TMR16_PR_ES_LO      4
`define TMR16_PR_ES_HI      5
`define TMR16_PR_ES1_LO     6
`define TMR16_PR_ES1_HI     7
// edge encodings
`define TMR16_EDGE_FALL     2'b00
`define TMR16_EDGE_RISE     2'b01
`define TMR16_EDGE_BOTH     2'b11
// count clock selects
`define TMR16_CLK_EXT       2'b11
// status fields
`define TMR16_ST_CYC_FLAG   0
`define TMR16_ST_DUTY_FLAG  1
// constants
`define TMR16_ZERO16        16'h0000
`define TMR16_ONE16         16'h0001
`define TMR16_MAX16         16'hFFFF
`define TMR16_DIV_W         4
`define TMR16_DIV_ONE       4'h1
`define TMR16_DIV_2         4'h1
`define TMR16_DIV_4         4'h3
`define TMR16_DIV_16        4'hF
`define TMR16_FILT_ONES     2'b11
`define TMR16_FILT_ZEROS    2'b00
`endif

// ---- tmr16_top.v ----
// 16-bit timer/event counter with two capture/compare registers and a one-shot output
// assumes one clock; edge pins are asynchronous and pass two flip-flops first
// Notes on behaviour
// - counter runs whenever run-mode bits are nonzero, stops when written to zero-zero
// - counter reads never load duty register and lose no count pulse
// - stopped timer neither counts nor raises match events, whatever the pins do
// - compare zero matches on the wrap step from zero to one in free/edge modes
// - compare below count: counter keeps counting, wraps, then matches
// - one-shot trigger self-clears; trigger, level-set and level-reset read zero
// - one-shot only in free-running or edge-restart modes, never match-restart
// - primary edge still clears and restarts counter in software one-shot use
// - overflow flag sets when counter steps from maximum to zero
// - overflow clear before the count reaches one is undone by the flag
// - capture beats coincident write; capture at stop gives undefined data
// - no capture when both edges selected on the primary input
// - capture-source one: secondary edge raises cycle event but stores nothing
// - capture on count clock fall phase, event on the second rise phase after it
// - pins filtered on peripheral clock for counting, count clock for capture
// - pin already high when enabled is seen as an edge for rising or both-edge select
// - event counting starts only after two valid edges
`include "tmr16_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tmr16_top (
    // clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [15:0] reg_rdata,
    // pins
    input  wire        primary_edge_input,
    input  wire        secondary_edge_input,
    output reg         timer_output_pin,
    // events
    output reg         cycle_match_irq,
    output reg         duty_match_irq
);
    reg  [15:0] main_counter_r;
    reg  [15:0] cycle_capcmp_reg_r;
    reg  [15:0] duty_capcmp_reg_r;
    reg  [15:0] mode_control_reg_r;
    reg  [15:0] capcmp_control_reg_r;
    reg  [15:0] output_control_reg_r;
    reg  [15:0] prescaler_reg_r;
    reg  [`TMR16_DIV_W-1:0] div_r;
    reg  [1:0]  sync_a_r;
    reg  [1:0]  sync_b_r;
    reg  [1:0]  filt_a_r;
    reg  [1:0]  filt_b_r;
    reg         lvl_a_r;
    reg         lvl_b_r;
    reg         cnt_lvl_r;
    reg         run_d_r;
    reg  [1:0]  ev_seen_r;
    reg         os_arm_r;
    reg         os_pend_r;
    reg         cap_cyc_pend_r;
    reg         cap_duty_pend_r;
    reg         ovf_hold_r;
    reg  [1:0]  status_r;
    // derived controls
    wire [1:0]  run_mode    = {mode_control_reg_r[`TMR16_MODE_RUN_HI], mode_control_reg_r[`TMR16_MODE_RUN_LO]};
    wire        running     = (run_mode != `TMR16_RUN_STOP);
    wire [1:0]  clk_sel     = {prescaler_reg_r[`TMR16_PR_CLK_HI], prescaler_reg_r[`TMR16_PR_CLK_LO]};
    wire [1:0]  es_a        = {prescaler_reg_r[`TMR16_PR_ES_HI], prescaler_reg_r[`TMR16_PR_ES_LO]};
    wire [1:0]  es_b        = {prescaler_reg_r[`TMR16_PR_ES1_HI], prescaler_reg_r[`TMR16_PR_ES1_LO]};
    wire        ext_clk     = (clk_sel == `TMR16_CLK_EXT);
    wire        cnt_read    = reg_read && (reg_addr == `TMR16_ADDR_COUNT);
    wire [`TMR16_DIV_W-1:0] div_top = (clk_sel == 2'b00) ? `TMR16_DIV_2 :
                                      (clk_sel == 2'b01) ? `TMR16_DIV_4 : `TMR16_DIV_16;
    // count clock phases: rise at div wrap, fall at half period
    wire        rise_ph     = running && !ext_clk && (div_r == div_top);
    wire        fall_ph     = running && !ext_clk && (div_r == (div_top >> 1));
    // a level is accepted after two equal samples
    wire        a_new       = (filt_a_r == `TMR16_FILT_ONES) ? 1'b1 :
                              (filt_a_r == `TMR16_FILT_ZEROS) ? 1'b0 : lvl_a_r;
    wire        b_new       = (filt_b_r == `TMR16_FILT_ONES) ? 1'b1 :
                              (filt_b_r == `TMR16_FILT_ZEROS) ? 1'b0 : lvl_b_r;
    // edge select; zero reference while stopped shows a pre-set pin as an edge
    function edge_hit;
        input [1:0] es;
        input       prev;
        input       now;
        begin
            edge_hit = ((es == `TMR16_EDGE_RISE) && !prev && now) ||
                       ((es == `TMR16_EDGE_FALL) && prev && !now) ||
                       ((es == `TMR16_EDGE_BOTH) && (prev != now));
        end
    endfunction
    wire        a_edge      = running && edge_hit(es_a, lvl_a_r, a_new);
    wire        b_edge      = running && edge_hit(es_b, lvl_b_r, b_new);
    wire        a_cnt_edge  = running && ext_clk && edge_hit(es_a, cnt_lvl_r, sync_a_r[1]);
    // count steps: external event counting waits for two edges
    wire        ext_step    = a_cnt_edge && (ev_seen_r == 2'b11);
    // a counter read holds the step for one cycle
    wire        step_raw    = (rise_ph || ext_step || os_pend_r);
    wire        step        = step_raw && !cnt_read;
    wire        os_trig_wr  = reg_write && (reg_addr == `TMR16_ADDR_OUTCTL) && reg_wdata[`TMR16_OC_OS_TRIG];
    wire        os_ok       = output_control_reg_r[`TMR16_OC_OS_EN] &&
                              (run_mode == `TMR16_RUN_FREE || run_mode == `TMR16_RUN_EDGE);
    // primary edge restarts in edge mode and one-shot use
    wire        restart     = a_edge && !ext_clk &&
                              (run_mode == `TMR16_RUN_EDGE || output_control_reg_r[`TMR16_OC_OS_EN]);
    wire        soft_start  = os_trig_wr && os_ok;
    wire        wrap        = step && (main_counter_r == `TMR16_MAX16);
    wire        match_clear = step && (run_mode == `TMR16_RUN_MATCH) && (main_counter_r == cycle_capcmp_reg_r);
    wire [15:0] cnt_next    = main_counter_r + `TMR16_ONE16;
    // compares are checked on the value being left, so zero matches on 0 -> 1 after wrap
    wire        cyc_match   = step && !capcmp_control_reg_r[`TMR16_CC_CYC_CAP] &&
                              (main_counter_r == cycle_capcmp_reg_r) &&
                              !(main_counter_r == `TMR16_ZERO16 && run_mode == `TMR16_RUN_MATCH);
    wire        duty_match  = step && !capcmp_control_reg_r[`TMR16_CC_DUTY_CAP] &&
                              (main_counter_r == duty_capcmp_reg_r);
    // capture triggers: primary into duty and cycle; secondary only raises the cycle event
    wire        cap_trig_a  = a_edge && (es_a != `TMR16_EDGE_BOTH);
    wire        cyc_trig    = capcmp_control_reg_r[`TMR16_CC_SRC] ? b_edge : cap_trig_a;
    wire        cyc_store   = capcmp_control_reg_r[`TMR16_CC_CYC_CAP] && cyc_trig &&
                              !capcmp_control_reg_r[`TMR16_CC_SRC];
    wire        duty_store  = capcmp_control_reg_r[`TMR16_CC_DUTY_CAP] && cap_trig_a;

    // input synchronisers, peripheral clock
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_a_r  <= 2'b00;
            sync_b_r  <= 2'b00;
            cnt_lvl_r <= 1'b0;
        end else begin
            sync_a_r  <= {sync_a_r[0], primary_edge_input};
            sync_b_r  <= {sync_b_r[0], secondary_edge_input};
            cnt_lvl_r <= running ? sync_a_r[1] : 1'b0;  // count-clock filter on peripheral clock
        end
    end

    // capture filters sample at count clock rise; level reference is zero while stopped
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            filt_a_r <= 2'b00;
            filt_b_r <= 2'b00;
            lvl_a_r  <= 1'b0;
            lvl_b_r  <= 1'b0;
        end else if (!running) begin
            filt_a_r <= 2'b00;
            filt_b_r <= 2'b00;
            lvl_a_r  <= 1'b0;
            lvl_b_r  <= 1'b0;
        end else if (rise_ph) begin
            filt_a_r <= {filt_a_r[0], sync_a_r[1]};
            filt_b_r <= {filt_b_r[0], sync_b_r[1]};
            lvl_a_r  <= a_new;
            lvl_b_r  <= b_new;
        end
    end

    // prescaler divider and event-count qualifier
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_r     <= {`TMR16_DIV_W{1'b0}};
            ev_seen_r <= 2'b00;
            run_d_r   <= 1'b0;
        end else begin
            run_d_r <= running;
            if (!running) begin
                div_r     <= {`TMR16_DIV_W{1'b0}};
                ev_seen_r <= 2'b00;
            end else begin
                div_r <= (div_r == div_top) ? {`TMR16_DIV_W{1'b0}} : div_r + `TMR16_DIV_ONE;
                if (a_cnt_edge && ev_seen_r != 2'b11)
                    ev_seen_r <= {ev_seen_r[0], 1'b1};
            end
        end
    end

    // main counter: run control, restart and read pause
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            main_counter_r <= `TMR16_ZERO16;
            os_pend_r      <= 1'b0;
        end else if (!running) begin
            main_counter_r <= `TMR16_ZERO16;
            os_pend_r      <= 1'b0;
        end else begin
            os_pend_r <= step_raw && cnt_read;
            if (restart || soft_start)
                main_counter_r <= `TMR16_ZERO16;
            else if (match_clear)
                main_counter_r <= `TMR16_ZERO16;
            else if (step)
                main_counter_r <= cnt_next;
        end
    end

    // compare/capture registers; fall-phase capture beats writes
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cycle_capcmp_reg_r <= `TMR16_ZERO16;
            duty_capcmp_reg_r  <= `TMR16_ZERO16;
            cap_cyc_pend_r     <= 1'b0;
            cap_duty_pend_r    <= 1'b0;
        end else begin
            if (cyc_trig && running)
                cap_cyc_pend_r <= 1'b1;
            else if (rise_ph || ext_clk)
                cap_cyc_pend_r <= 1'b0;
            if (duty_store)
                cap_duty_pend_r <= 1'b1;
            else if (rise_ph || ext_clk)
                cap_duty_pend_r <= 1'b0;
            if (cyc_store && (fall_ph || ext_clk))
                cycle_capcmp_reg_r <= main_counter_r;
            else if (reg_write && reg_addr == `TMR16_ADDR_CYCLE)
                cycle_capcmp_reg_r <= reg_wdata;
            if (duty_store && (fall_ph || ext_clk))
                duty_capcmp_reg_r <= main_counter_r;
            else if (reg_write && reg_addr == `TMR16_ADDR_DUTY)
                duty_capcmp_reg_r <= reg_wdata;
        end
    end

    // control registers; overflow set beats a clear until count one
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_control_reg_r   <= `TMR16_ZERO16;
            capcmp_control_reg_r <= `TMR16_ZERO16;
            output_control_reg_r <= `TMR16_ZERO16;
            prescaler_reg_r      <= `TMR16_ZERO16;
            ovf_hold_r           <= 1'b0;
        end else begin
            if (reg_write && reg_addr == `TMR16_ADDR_MODE)
                mode_control_reg_r <= reg_wdata;
            if (wrap || (ovf_hold_r && running))
                mode_control_reg_r[`TMR16_MODE_OVF] <= 1'b1;
            if (wrap)
                ovf_hold_r <= 1'b1;
            else if (step || !running)
                ovf_hold_r <= 1'b0;
            if (reg_write && reg_addr == `TMR16_ADDR_CAPCMP)
                capcmp_control_reg_r <= reg_wdata;
            if (reg_write && reg_addr == `TMR16_ADDR_OUTCTL)
                output_control_reg_r <= reg_wdata & `TMR16_OC_MASK;
            if (reg_write && reg_addr == `TMR16_ADDR_PRESC)
                prescaler_reg_r <= reg_wdata;
        end
    end

    // event outputs and sticky status; secondary edge still raises the cycle event
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cycle_match_irq <= 1'b0;
            duty_match_irq  <= 1'b0;
            status_r        <= 2'b00;
        end else begin
            // the trigger lasts into the next rise phase; waiting for its end gives one event
            cycle_match_irq <= running && (cyc_match || (cap_cyc_pend_r && !cyc_trig && (rise_ph || ext_clk)));
            duty_match_irq  <= running && (duty_match || (cap_duty_pend_r && !duty_store && (rise_ph || ext_clk)));
            if (reg_write && reg_addr == `TMR16_ADDR_STATUS)
                status_r <= status_r & ~reg_wdata[1:0];
            if (cycle_match_irq)
                status_r[`TMR16_ST_CYC_FLAG] <= 1'b1;
            if (duty_match_irq)
                status_r[`TMR16_ST_DUTY_FLAG] <= 1'b1;
        end
    end

    // timer output: match toggles; one-shot set at duty, cleared at cycle
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_output_pin <= 1'b0;
            os_arm_r         <= 1'b0;
        end else begin
            if (!output_control_reg_r[`TMR16_OC_ENABLE]) begin
                timer_output_pin <= 1'b0;
            end else if (reg_write && reg_addr == `TMR16_ADDR_OUTCTL && reg_wdata[`TMR16_OC_LVL_SET]) begin
                timer_output_pin <= 1'b1;
            end else if (reg_write && reg_addr == `TMR16_ADDR_OUTCTL && reg_wdata[`TMR16_OC_LVL_RST]) begin
                timer_output_pin <= 1'b0;
            end else if (output_control_reg_r[`TMR16_OC_OS_EN]) begin
                if (os_ok && duty_match && os_arm_r)
                    timer_output_pin <= 1'b1;
                else if (os_ok && cyc_match)
                    timer_output_pin <= 1'b0;
            end else if ((cyc_match && output_control_reg_r[`TMR16_OC_CYC_TGL]) ||
                         (duty_match && output_control_reg_r[`TMR16_OC_DUTY_TGL])) begin
                timer_output_pin <= ~timer_output_pin;
            end
            if ((soft_start || (restart && os_ok)))
                os_arm_r <= 1'b1;
            else if (os_ok && cyc_match)
                os_arm_r <= 1'b0;
        end
    end

    // read data one cycle after the strobe; trigger and level bits read zero
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `TMR16_ZERO16;
        end else if (reg_read) begin
            if (reg_addr == `TMR16_ADDR_COUNT)
                reg_rdata <= main_counter_r;
            else if (reg_addr == `TMR16_ADDR_CYCLE)
                reg_rdata <= cycle_capcmp_reg_r;
            else if (reg_addr == `TMR16_ADDR_DUTY)
                reg_rdata <= duty_capcmp_reg_r;
            else if (reg_addr == `TMR16_ADDR_MODE)
                reg_rdata <= mode_control_reg_r;
            else if (reg_addr == `TMR16_ADDR_CAPCMP)
                reg_rdata <= capcmp_control_reg_r;
            else if (reg_addr == `TMR16_ADDR_OUTCTL)
                reg_rdata <= output_control_reg_r & `TMR16_OC_RD_MASK;
            else if (reg_addr == `TMR16_ADDR_PRESC)
                reg_rdata <= prescaler_reg_r;
            else if (reg_addr == `TMR16_ADDR_STATUS)
                reg_rdata <= {14'h0000, status_r};
            else
                reg_rdata <= `TMR16_ZERO16;
        end else begin
            reg_rdata <= `TMR16_ZERO16;
        end
    end
endmodule // tmr16_top
`default_nettype wire

// ---- tmr16_monitor.sv ----
// checker for tmr16_top: reads, event pulses, counter
// assumes a bind to tmr16_top; sees its ports only
`include "tmr16_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tmr16_monitor (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [15:0] reg_rdata,
    // pins and events
    input wire logic        primary_edge_input,
    input wire logic        secondary_edge_input,
    input wire logic        timer_output_pin,
    input wire logic        cycle_match_irq,
    input wire logic        duty_match_irq
);
    logic [1:0] run_r, clk_r;
    logic [7:0] age_r;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // shadow of run mode and clock select; age saturates
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            run_r <= 2'b00;
            clk_r <= 2'b00;
            age_r <= 8'h00;
        end else begin
            if (reg_write && reg_addr == `TMR16_ADDR_MODE) begin
                run_r <= reg_wdata[`TMR16_MODE_RUN_HI:`TMR16_MODE_RUN_LO];
                age_r <= 8'h00;
            end else if (age_r != 8'hFF) begin
                age_r <= age_r + 8'h01;
            end
            if (reg_write && reg_addr == `TMR16_ADDR_PRESC) begin
                clk_r <= reg_wdata[1:0];
            end
        end
    end
    // read strobes of interest
    sequence s_rd_count;
        reg_read && reg_addr == `TMR16_ADDR_COUNT;
    endsequence
    sequence s_rd_outctl;
        reg_read && reg_addr == `TMR16_ADDR_OUTCTL;
    endsequence
    property p_rst_quiet;
        $rose(rst_n) |-> !cycle_match_irq && !duty_match_irq && !timer_output_pin && reg_rdata == 16'h0000;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs active at reset release");
    property p_rdata_idle;
        !$past(reg_read) |-> reg_rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");
    property p_cyc_pulse;
        cycle_match_irq |=> !cycle_match_irq;
    endproperty
    a_cyc_pulse: assert property (p_cyc_pulse)
        else $error("cycle event over one cycle");
    property p_duty_pulse;
        duty_match_irq |=> !duty_match_irq;
    endproperty
    a_duty_pulse: assert property (p_duty_pulse)
        else $error("duty event over one cycle");
    property p_outctl_zero;
        s_rd_outctl |=> reg_rdata[`TMR16_OC_OS_TRIG] == 1'b0 && reg_rdata[3:2] == 2'b00;
    endproperty
    a_outctl_zero: assert property (p_outctl_zero)
        else $error("write-only bits read nonzero");
    property p_stop_quiet;
        run_r == `TMR16_RUN_STOP && age_r >= 8'h10 |-> !cycle_match_irq && !duty_match_irq;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("event while stopped");
    property p_stop_count;
        s_rd_count ##0 (run_r == `TMR16_RUN_STOP && age_r >= 8'h04) |=> reg_rdata == 16'h0000;
    endproperty
    a_stop_count: assert property (p_stop_count)
        else $error("stopped counter not zero");
    property p_run_count;
        s_rd_count ##0 (run_r == `TMR16_RUN_FREE && clk_r != `TMR16_CLK_EXT && age_r >= 8'h28)
            |=> reg_rdata != 16'h0000;
    endproperty
    a_run_count: assert property (p_run_count)
        else $error("free counter did not advance");
endmodule // tmr16_monitor
bind tmr16_top tmr16_monitor mon (.*);
`default_nettype wire

// ---- tmr16_pin_model.sv ----
// source for the two edge pins
// assumes the count clock runs at clock/4 or faster
`timescale 1ns/1ps
`default_nettype none
module tmr16_pin_model (
    // clock
    input  wire logic clock,
    // pins
    output var  logic primary_edge_input,
    output var  logic secondary_edge_input
);
    initial begin
        primary_edge_input = 1'b0;
        secondary_edge_input = 1'b0;
    end
    // each phase 12+ clocks, so the filter keeps it
    task automatic pulse(input logic sel, input int width);
        @(posedge clock);
        if (sel) secondary_edge_input <= 1'b1;
        else primary_edge_input <= 1'b1;
        repeat (width + 12) @(posedge clock);
        primary_edge_input <= 1'b0;
        secondary_edge_input <= 1'b0;
        repeat (width + 12) @(posedge clock);
    endtask
endmodule // tmr16_pin_model
`default_nettype wire

// ---- tb_tmr16_top.sv ----
// bench for tmr16_top: bus, run modes, compares, captures, events
// assumes tmr16_pin_model drives pins, tmr16_monitor is bound
`include "tmr16_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_tmr16_top;
    logic        clock;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    wire  [15:0] reg_rdata;
    wire         primary_edge_input;
    wire         secondary_edge_input;
    wire         timer_output_pin;
    wire         cycle_match_irq;
    wire         duty_match_irq;
    int          mismatches, cmp_count, cyc_n, duty_n, c0, d0, n;
    logic [15:0] a, b;
    logic [1:0]  es_tab [3] = '{`TMR16_EDGE_FALL, `TMR16_EDGE_RISE, `TMR16_EDGE_BOTH};
    tmr16_top dut (.*);
    tmr16_pin_model pins (.*);
    // 200 MHz clock
    always #2.5 clock = ~clock;
    // event tallies
    always @(posedge clock) begin
        if (cycle_match_irq === 1'b1) cyc_n++;
        if (duty_match_irq === 1'b1) duty_n++;
    end
    function automatic logic [15:0] run_word(input logic [1:0] m);
        return 16'(m) << `TMR16_MODE_RUN_LO;
    endfunction
    function automatic logic [15:0] cap_exp(input logic [1:0] es);
        return 16'(es != `TMR16_EDGE_BOTH); // both edges selected: nothing stored
    endfunction
    task automatic wr(input logic [7:0] ad, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // read data stand one cycle only: sample just past the edge
    task automatic rd(input logic [7:0] ad, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= ad;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdchk(input string nm, input logic [7:0] ad, input logic [15:0] e);
        logic [15:0] v;
        rd(ad, v);
        chk(nm, e, v);
    endtask
    task automatic stop_test;
        $display("counts: %0d compared, %0d mismatched", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog: tests need under 20000 clocks
    initial begin
        #200000;
        mismatches++;
        $display("watchdog expired");
        stop_test;
    end
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        n = $urandom(25237);
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        rdchk("mode reset", `TMR16_ADDR_MODE, 16'h0000);
        wr(8'h3F, 16'hFFFF);
        rdchk("unmapped", 8'h3F, 16'h0000);
        wr(`TMR16_ADDR_OUTCTL, 16'h007F);
        rdchk("outctl", `TMR16_ADDR_OUTCTL, 16'h0033);
        wr(`TMR16_ADDR_OUTCTL, 16'h0000);
        $display("test registers done");
        c0 = cyc_n + duty_n;
        pins.pulse(1'b0, 4);
        pins.pulse(1'b1, 4);
        rdchk("stopped count", `TMR16_ADDR_COUNT, 16'h0000);
        chk("stopped events", 16'(c0), 16'(cyc_n + duty_n));
        $display("test stopped done");
        // each run mode counts, clears when stopped
        wr(`TMR16_ADDR_CYCLE, `TMR16_MAX16);
        wr(`TMR16_ADDR_PRESC, 16'h0000);
        for (int i = 1; i < 4; i++) begin
            wr(`TMR16_ADDR_MODE, run_word(2'(i)));
            repeat (20) @(posedge clock);
            rd(`TMR16_ADDR_COUNT, a);
            repeat (20) @(posedge clock);
            rd(`TMR16_ADDR_COUNT, b);
            chk("count step", 16'h0001, 16'(b - a >= 16'h0009 && b - a <= 16'h000D));
            wr(`TMR16_ADDR_MODE, 16'h0000);
            rdchk("count stop", `TMR16_ADDR_COUNT, 16'h0000);
        end
        $display("test run modes done");
        // compare matches; pass 0 uses compare one, then zero
        wr(`TMR16_ADDR_CAPCMP, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            n = (i == 0) ? 1 : $urandom_range(60, 8);
            wr(`TMR16_ADDR_CYCLE, 16'(n));
            wr(`TMR16_ADDR_DUTY, 16'((n + 1) / 2));
            wr(`TMR16_ADDR_STATUS, 16'h0003);
            c0 = cyc_n;
            d0 = duty_n;
            wr(`TMR16_ADDR_MODE, run_word(`TMR16_RUN_FREE));
            repeat (2 * n + 30) @(posedge clock);
            chk("cycle match", 16'(c0 + 1), 16'(cyc_n));
            chk("duty match", 16'(d0 + 1), 16'(duty_n));
            rdchk("flags set", `TMR16_ADDR_STATUS, 16'h0003);
            wr(`TMR16_ADDR_STATUS, 16'h0003);
            rdchk("flags clear", `TMR16_ADDR_STATUS, 16'h0000);
            wr(`TMR16_ADDR_CYCLE, 16'(n - 1));
            repeat (40) @(posedge clock);
            chk("below count", 16'(c0 + 1), 16'(cyc_n));
            wr(`TMR16_ADDR_MODE, 16'h0000);
        end
        $display("test compare done");
        // capture source secondary: event, no store
        wr(`TMR16_ADDR_CYCLE, 16'h1234);
        wr(`TMR16_ADDR_CAPCMP, 16'h0003);
        wr(`TMR16_ADDR_PRESC, 16'(`TMR16_EDGE_RISE) << `TMR16_PR_ES1_LO);
        c0 = cyc_n;
        wr(`TMR16_ADDR_MODE, run_word(`TMR16_RUN_FREE));
        pins.pulse(1'b1, $urandom_range(16, 12));
        chk("source event", 16'(c0 + 1), 16'(cyc_n));
        rdchk("source no store", `TMR16_ADDR_CYCLE, 16'h1234);
        wr(`TMR16_ADDR_MODE, 16'h0000);
        $display("test capture source done");
        // primary capture for each edge code
        for (int i = 0; i < 3; i++) begin
            wr(`TMR16_ADDR_DUTY, 16'h0ABC);
            wr(`TMR16_ADDR_CAPCMP, 16'h0004);
            wr(`TMR16_ADDR_PRESC, 16'(es_tab[i]) << `TMR16_PR_ES_LO);
            d0 = duty_n;
            wr(`TMR16_ADDR_MODE, run_word(`TMR16_RUN_FREE));
            repeat (10) @(posedge clock);
            pins.pulse(1'b0, $urandom_range(16, 12));
            rd(`TMR16_ADDR_DUTY, a);
            chk("duty capture", cap_exp(es_tab[i]), 16'(a !== 16'h0ABC));
            if (es_tab[i] != `TMR16_EDGE_BOTH) chk("capture event", 16'(d0 + 1), 16'(duty_n));
            wr(`TMR16_ADDR_MODE, 16'h0000);
        end
        $display("test capture edges done");
        // event counting waits for two edges
        wr(`TMR16_ADDR_CAPCMP, 16'h0000);
        wr(`TMR16_ADDR_PRESC, 16'h0013);
        wr(`TMR16_ADDR_MODE, run_word(`TMR16_RUN_FREE));
        pins.pulse(1'b0, 0);
        rdchk("one edge", `TMR16_ADDR_COUNT, 16'h0000);
        repeat (4) pins.pulse(1'b0, 0);
        rd(`TMR16_ADDR_COUNT, a);
        chk("event count", 16'h0001, 16'(a >= 16'h0002 && a <= 16'h0004));
        wr(`TMR16_ADDR_MODE, 16'h0000);
        $display("test event count done");
        stop_test;
    end
endmodule // tb_tmr16_top
`default_nettype wire
